/* File: hdl/test_route_mux.sv */
`timescale 1ns/100ps
`include "test_space_map.svh"

module test_route_mux
    import test_space_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] sel,
    input  wire route_src_s src,
    output logic            pin
);

    route_state_s q;
    route_state_s d;

    function automatic logic pick(input logic [3:0] s, input logic [11:0] v);
        logic [3:0] k;
        k = s - 4'h1;
        if (s == `ROUTE_GND || s > `ROUTE_LAST) begin
            return 1'b0;
        end
        return v[k];
    endfunction

    always_comb begin
        d = q;
        // two-stage capture of foreign signals
        d.sync1 = src;
        d.sync2 = q.sync1;
        d.pin = pick(sel, q.sync2);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin = q.pin;

    property p_route_gnd;
        @(posedge clk) disable iff (!rst_n)
        (sel == `ROUTE_GND) |=> !pin;
    endproperty
    a_route_gnd: assert property (p_route_gnd)
        else $error("test pin not grounded for code zero");

endmodule // test_route_mux

/* File: hdl/test_space_control_registers.sv */
`timescale 1ns/100ps
`include "test_space_map.svh"

// Function
// - A 4-bit select routes ground, array clock, bitstreams or clocks to the test pin.
// - Select codes 08 to 0C route acknowledge lines 5, 7, 8, 9 and 10 to the test pin.
// - Bits 2:0 of the access control register pick one of six banks, 0 to 5.
// - Program enable set to 1 lets the external interface program the memory.
// - With ignore at 0, program enable clears 15 ms after the interface sets it.
// - With ignore at 1, no timeout applies and program enable stays until written.
// - Writing 1 to reload forces the selected bank into the cache; 0 does nothing.
// - The owner bit gives memory to the core at 0 and to the interface at 1.
// - The hold bit keeps the core in reset while it is 1.
// - Error bit 0 sets when the sync bit rate is below 2000 bits per second.
// - Error bit 1 sets when the sync bit rate crosses the 25 kbps limit.
// - Error bit 2 sets when the sync stop bit is too short.
// - Error bits 3 and 4 set on a bad or short command stop bit.
// - Error bits 5 and 6 set on a bad or short data stop bit.
// - Error bit 7 sets when the line is overdriven during our stop bit.
module test_space_control_registers
    import test_space_pkg::*;
#(
    parameter int PROG_TIMEOUT_CYCLES = `PROG_TIMEOUT_CYC,
    parameter int SYNC_SLOW_CYCLES    = `SYNC_SLOW_CYC,
    parameter int SYNC_FAST_CYCLES    = `SYNC_FAST_CYC
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        extIfWrite,
    input  wire ow_rx_s      owRx,
    input  wire route_src_s  routeSrc,
    output nvm_ctrl_s        nvm,
    output logic             digitalTestPin,
    output logic             irq
);

    if (PROG_TIMEOUT_CYCLES < 1 || PROG_TIMEOUT_CYCLES >= (1 << 21)) begin : g_bad_prog
        $error("program timeout out of range");
    end
    if (SYNC_FAST_CYCLES < 1 || SYNC_FAST_CYCLES >= SYNC_SLOW_CYCLES
        || SYNC_SLOW_CYCLES >= (1 << 20)) begin : g_bad_sync
        $error("sync rate limits out of range");
    end

    localparam logic [20:0] PROG_LAST = 21'(PROG_TIMEOUT_CYCLES - 1);
    localparam logic [19:0] SLOW_LIM  = 20'(SYNC_SLOW_CYCLES);
    localparam logic [19:0] FAST_LIM  = 20'(SYNC_FAST_CYCLES);

    regs_state_s q;
    regs_state_s d;

    logic       wen;
    logic       wrRoute;
    logic       wrNvm;
    logic       wrOwner;
    logic       wrErr;
    logic       wrStat;
    logic       wrMask;
    logic [7:0] owSet;
    logic [7:0] wbyte;

    function automatic logic hits(input logic [9:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    function automatic logic mapped(input logic [9:0] a);
        return hits(a, `IDX_ROUTE) || hits(a, `IDX_NVM)
            || hits(a, `IDX_OWNER) || hits(a, `IDX_OW_ERR)
            || hits(a, `IDX_IRQ_STAT) || hits(a, `IDX_IRQ_MASK);
    endfunction

    function automatic logic [7:0] readByte(input logic [9:0] a,
                                            input regs_state_s s);
        logic [7:0] r;
        r = `RST_BYTE;
        if (hits(a, `IDX_ROUTE)) begin
            r = {4'h0, s.route};
        end else if (hits(a, `IDX_NVM)) begin
            r = {2'b00, s.reloadBit, s.ignore, s.progEn, s.bank};
        end else if (hits(a, `IDX_OWNER)) begin
            r = {6'h00, s.coreHold, s.ownerExt};
        end else if (hits(a, `IDX_OW_ERR)) begin
            r = s.owErr;
        end else if (hits(a, `IDX_IRQ_STAT)) begin
            r = s.irqStat;
        end else if (hits(a, `IDX_IRQ_MASK)) begin
            r = s.irqMask;
        end
        return r;
    endfunction

    // write lands at the access edge, never to an unmapped word
    assign wen     = psel && penable && pwrite && !q.slvErr;
    assign wrRoute = wen && hits(paddr, `IDX_ROUTE);
    assign wrNvm   = wen && hits(paddr, `IDX_NVM);
    assign wrOwner = wen && hits(paddr, `IDX_OWNER);
    assign wrErr   = wen && hits(paddr, `IDX_OW_ERR);
    assign wrStat  = wen && hits(paddr, `IDX_IRQ_STAT);
    assign wrMask  = wen && hits(paddr, `IDX_IRQ_MASK);
    assign wbyte   = pwdata[7:0];

    always_comb begin
        owSet = 8'h00;
        if (owRx.syncValid) begin
            owSet[0] = owRx.syncBitCycles > SLOW_LIM;
            owSet[1] = owRx.syncBitCycles < FAST_LIM;
        end
        owSet[2] = owRx.syncStopShort;
        owSet[3] = owRx.cmdStopBad;
        owSet[4] = owRx.cmdStopShort;
        owSet[5] = owRx.dataStopBad;
        owSet[6] = owRx.dataStopShort;
        owSet[7] = owRx.txOverdriven;
    end

    always_comb begin
        d = q;
        d.reloadPulse = 1'b0;

        // setup phase captures the answer
        if (psel && !penable) begin
            d.slvErr = !mapped(paddr);
            d.rdata  = readByte(paddr, q);
        end

        if (wrRoute) begin
            d.route = wbyte[3:0];
        end

        case (q.prog)
            PROG_IDLE: begin
                d.progCnt = '0;
            end
            PROG_TIMING: begin
                if (q.progCnt == PROG_LAST) begin
                    d.progEn = 1'b0;
                    d.prog   = PROG_IDLE;
                end else begin
                    d.progCnt = q.progCnt + 21'd1;
                end
            end
            default: begin
                d.prog = PROG_IDLE;
            end
        endcase

        if (wrNvm) begin
            // codes 6 and 7 keep the old bank
            if (wbyte[`NVM_BANK_MSB:0] <= `NVM_BANK_MAX) begin
                d.bank = wbyte[`NVM_BANK_MSB:0];
            end
            d.progEn    = wbyte[`NVM_PROG_BIT];
            d.ignore    = wbyte[`NVM_IGN_BIT];
            d.reloadBit = wbyte[`NVM_RELOAD_BIT];
            d.reloadPulse = wbyte[`NVM_RELOAD_BIT];
            d.progCnt     = '0;
            if (wbyte[`NVM_PROG_BIT] && !wbyte[`NVM_IGN_BIT]) begin
                d.prog = (extIfWrite || q.prog == PROG_TIMING) ? PROG_TIMING : PROG_IDLE;
            end else begin
                d.prog = PROG_IDLE;
            end
        end

        if (wrOwner) begin
            d.ownerExt = wbyte[`OWN_EXT_BIT];
            d.coreHold = wbyte[`OWN_HOLD_BIT];
        end

        // sticky, set wins; error flags clear on write 0, status bits on write 1
        if (wrErr) begin
            d.owErr = (q.owErr & wbyte) | owSet;
        end else begin
            d.owErr = q.owErr | owSet;
        end

        if (wrStat) begin
            d.irqStat = (q.irqStat & ~wbyte) | owSet;
        end else begin
            d.irqStat = q.irqStat | owSet;
        end

        if (wrMask) begin
            d.irqMask = wbyte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{route: `RST_ROUTE, bank: `RST_BANK, prog: PROG_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    test_route_mux u_route (
        .clk   (clk),
        .rst_n (rst_n),
        .sel   (q.route),
        .src   (routeSrc),
        .pin   (digitalTestPin)
    );

    assign pready  = psel && penable;
    assign pslverr = psel && penable && q.slvErr;
    assign prdata  = {24'h00_0000, q.rdata};

    assign nvm.bankSel     = q.bank;
    assign nvm.progEnable  = q.progEn;
    assign nvm.bankReload  = q.reloadPulse;
    assign nvm.memOwnerExt = q.ownerExt;
    assign nvm.coreHold    = q.coreHold;

    assign irq = |(q.irqStat & q.irqMask);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_reloadReq;
        wrNvm && wbyte[`NVM_RELOAD_BIT];
    endsequence

    sequence s_reloadPulse;
        nvm.bankReload ##1 !nvm.bankReload;
    endsequence

    sequence s_extProgSet;
        wrNvm && extIfWrite && wbyte[`NVM_PROG_BIT] && !wbyte[`NVM_IGN_BIT];
    endsequence

    property p_bank_range;
        nvm.bankSel <= `NVM_BANK_MAX;
    endproperty
    a_bank_range: assert property (p_bank_range)
        else $error("bank select outside six banks");

    property p_prog_start;
        s_extProgSet |=> nvm.progEnable && q.prog == PROG_TIMING && q.progCnt == '0;
    endproperty
    a_prog_start: assert property (p_prog_start)
        else $error("program enable or timer not started");

    property p_prog_timeout;
        (q.prog == PROG_TIMING && q.progCnt == PROG_LAST && !wrNvm)
            |=> !nvm.progEnable && q.prog == PROG_IDLE;
    endproperty
    a_prog_timeout: assert property (p_prog_timeout)
        else $error("program enable not cleared at timeout");

    property p_prog_early;
        (q.prog == PROG_TIMING && q.progCnt != PROG_LAST && nvm.progEnable && !wrNvm)
            |=> nvm.progEnable;
    endproperty
    a_prog_early: assert property (p_prog_early)
        else $error("program enable cleared before timeout");

    property p_ignore_hold;
        (nvm.progEnable && q.ignore && !wrNvm) |=> nvm.progEnable;
    endproperty
    a_ignore_hold: assert property (p_ignore_hold)
        else $error("program enable dropped while timeout ignored");

    property p_reload;
        s_reloadReq |=> s_reloadPulse;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload pulse missing or too long");

    property p_owner_hold;
        wrOwner |=> nvm.memOwnerExt == $past(wbyte[`OWN_EXT_BIT])
            && nvm.coreHold == $past(wbyte[`OWN_HOLD_BIT]);
    endproperty
    a_owner_hold: assert property (p_owner_hold)
        else $error("owner or core hold does not follow write");

    property p_sync_slow;
        (owRx.syncValid && owRx.syncBitCycles > SLOW_LIM) |=> q.owErr[0];
    endproperty
    a_sync_slow: assert property (p_sync_slow)
        else $error("slow sync not flagged");

    property p_sync_fast;
        (owRx.syncValid && owRx.syncBitCycles < FAST_LIM) |=> q.owErr[1];
    endproperty
    a_sync_fast: assert property (p_sync_fast)
        else $error("fast sync not flagged");

    property p_err_sticky;
        !wrErr |=> (q.owErr & $past(q.owErr)) == $past(q.owErr);
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error flag lost without a write");

    property p_irq_raise;
        (|(owSet & q.irqMask) && !wrMask) |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("unmasked event did not raise interrupt");

endmodule // test_space_control_registers

/* File: hdl/test_space_map.svh */
`ifndef TEST_SPACE_MAP_SVH
`define TEST_SPACE_MAP_SVH

// register indexes, byte address is index * 4
`define IDX_ROUTE      8'h09
`define IDX_NVM        8'h0D
`define IDX_OWNER      8'h0E
`define IDX_OW_ERR     8'h14
`define IDX_IRQ_STAT   8'h16
`define IDX_IRQ_MASK   8'h17

// field positions
`define NVM_BANK_MSB   2
`define NVM_PROG_BIT   3
`define NVM_IGN_BIT    4
`define NVM_RELOAD_BIT 5
`define OWN_EXT_BIT    0
`define OWN_HOLD_BIT   1
`define NVM_BANK_MAX   3'h5

// reset values
`define RST_ROUTE      4'h0
`define RST_BANK       3'h0
`define RST_BYTE       8'h00

// route select codes
`define ROUTE_GND      4'h0
`define ROUTE_LAST     4'hC

// timing
`define CLK_HZ          100000000
`define PROG_TIMEOUT_MS 15
`define PROG_TIMEOUT_CYC (`PROG_TIMEOUT_MS * (`CLK_HZ / 1000))
`define SYNC_MIN_BPS    2000
`define SYNC_MAX_BPS    25000
`define SYNC_SLOW_CYC   (`CLK_HZ / `SYNC_MIN_BPS)
`define SYNC_FAST_CYC   (`CLK_HZ / `SYNC_MAX_BPS)

`endif

/* File: hdl/test_space_pkg.sv */
package test_space_pkg;

    typedef enum logic {
        PROG_IDLE,
        PROG_TIMING
    } prog_e;

    typedef struct packed {
        logic        syncValid;
        logic [19:0] syncBitCycles;
        logic        syncStopShort;
        logic        cmdStopBad;
        logic        cmdStopShort;
        logic        dataStopBad;
        logic        dataStopShort;
        logic        txOverdriven;
    } ow_rx_s;

    typedef struct packed {
        logic [4:0] irqAck;
        logic       chargePumpClock;
        logic       chopperClock;
        logic       temperatureModClock;
        logic       pressureModClock;
        logic       temperatureBits;
        logic       pressureBits;
        logic       nvmArrayClock;
    } route_src_s;

    typedef struct packed {
        logic [2:0] bankSel;
        logic       progEnable;
        logic       bankReload;
        logic       memOwnerExt;
        logic       coreHold;
    } nvm_ctrl_s;

    typedef struct packed {
        logic [11:0] sync1;
        logic [11:0] sync2;
        logic        pin;
    } route_state_s;

    typedef struct packed {
        logic [3:0]  route;
        logic [2:0]  bank;
        logic        progEn;
        logic        ignore;
        logic        reloadBit;
        logic        reloadPulse;
        logic        ownerExt;
        logic        coreHold;
        logic [7:0]  owErr;
        logic [7:0]  irqStat;
        logic [7:0]  irqMask;
        prog_e       prog;
        logic [20:0] progCnt;
        logic [7:0]  rdata;
        logic        slvErr;
    } regs_state_s;

endpackage

/* File: sim/ow_host_model.sv */
`timescale 1ns/100ps

module ow_host_model
    import test_space_pkg::*;
(
    input  wire logic clk,
    output ow_rx_s     owRx,
    output route_src_s routeSrc
);
    initial begin
        owRx     = '0;
        routeSrc = '0;
    end

    task automatic set_src(input logic [11:0] v);
        @(posedge clk);
        routeSrc <= v;
    endtask

    task automatic pulse(input logic sv, input logic [19:0] cyc, input logic [5:0] fl);
        @(posedge clk);
        owRx <= {sv, cyc, fl};
        @(posedge clk);
        // bit period field no longer holds the measured value
        owRx <= {1'b0, ~cyc, 6'h00};
    endtask
endmodule // ow_host_model

/* File: sim/test_space_control_registers_tb.sv */
`timescale 1ns/100ps
`include "test_space_map.svh"

module test_space_control_registers_tb
    import test_space_pkg::*;
;
    localparam int TO = 20;
    logic        clk, rst_n, psel, penable, pwrite, extIfWrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, digitalTestPin, irq;
    nvm_ctrl_s   nvm;
    ow_rx_s      owRx;
    route_src_s  routeSrc;
    int          errors, n_tests;
    logic [32:0] expQ[$];
    logic [32:0] mExp;
    logic [7:0]  expErr, bankExp;
    logic [9:0]  regs[6] = '{10'h024, 10'h034, 10'h038, 10'h050, 10'h058, 10'h05C};

    test_space_control_registers #(
        .PROG_TIMEOUT_CYCLES(TO), .SYNC_SLOW_CYCLES(200), .SYNC_FAST_CYCLES(40)
    ) uut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extIfWrite(extIfWrite), .owRx(owRx), .routeSrc(routeSrc),
        .nvm(nvm), .digitalTestPin(digitalTestPin), .irq(irq)
    );

    ow_host_model host (.clk(clk), .owRx(owRx), .routeSrc(routeSrc));

    task automatic cmp_bus(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic cmp_sig(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                       input logic [32:0] e);
        @(posedge clk);
        expQ.push_back(e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'($urandom), d};
        @(posedge clk);
        // no answer during the setup cycle
        cmp_sig("pready", {7'h00, pready}, 8'h00);
        penable <= 1'b1;
        // wait for the answer, the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic err);
        apb(1'b1, a, d, {err, 32'h0000_0000});
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] v, input logic err);
        apb(1'b0, a, 8'h00, {err, 24'h00_0000, v});
    endtask

    function automatic logic exp_pin(input logic [3:0] c, input logic [11:0] s);
        return (c >= 4'h1 && c <= 4'hC) ? s[c - 4'h1] : 1'b0;
    endfunction

    task automatic all_zero;
        foreach (regs[i]) rd(regs[i], 8'h00, 1'b0);
    endtask

    task report_and_stop;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            mExp = expQ.pop_front();
            if (pwrite)
                cmp_bus("pslverr", {mExp[32], 32'h0000_0000}, {pslverr, 32'h0000_0000});
            else
                cmp_bus("prdata", mExp, {pslverr, prdata});
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #500000;
        errors++;
        report_and_stop;
    end

    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; extIfWrite = 1'b0; errors = 0; n_tests = 0; expErr = 8'h00;
        void'($urandom(32'hcdb40724));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        cmp_sig("nvm", 8'h00, {1'b0, nvm});
        cmp_sig("pin", 8'h00, {7'h00, digitalTestPin});
        all_zero();
        rd(10'h3FC, 8'h00, 1'b1);
        wr(10'h3FC, 8'hFF, 1'b1);
        for (int c = 0; c < 16; c++) begin
            wr(10'h024, 8'(c), 1'b0);
            rd(10'h024, 8'(c), 1'b0);
            for (int p = 0; p < 2; p++) begin
                host.set_src(12'($urandom));
                repeat (4) @(posedge clk);
                #1 cmp_sig("pin", {7'h00, exp_pin(4'(c), routeSrc)}, {7'h00, digitalTestPin});
            end
        end
        bankExp = 8'h00;
        for (int b = 0; b < 8; b++) begin
            wr(10'h034, 8'(b), 1'b0);
            if (b <= 5) bankExp = 8'(b);
            #1 cmp_sig("bank", bankExp, {5'h00, nvm.bankSel});
        end
        wr(10'h034, 8'h25, 1'b0);
        #1 cmp_sig("reload", {7'h00, nvm.bankReload}, 8'h01);
        @(posedge clk);
        #1 cmp_sig("reload", {7'h00, nvm.bankReload}, 8'h00);
        wr(10'h034, 8'h05, 1'b0);
        #1 cmp_sig("reload", {7'h00, nvm.bankReload}, 8'h00);
        @(posedge clk) extIfWrite <= 1'b1;
        wr(10'h034, 8'h08, 1'b0);
        #1 cmp_sig("prog", {7'h00, nvm.progEnable}, 8'h01);
        repeat (TO - 2) @(posedge clk);
        #1 cmp_sig("prog", {7'h00, nvm.progEnable}, 8'h01);
        repeat (4) @(posedge clk);
        #1 cmp_sig("prog", {7'h00, nvm.progEnable}, 8'h00);
        wr(10'h034, 8'h18, 1'b0);
        repeat (2 * TO) @(posedge clk);
        #1 cmp_sig("prog", {7'h00, nvm.progEnable}, 8'h01);
        @(posedge clk) extIfWrite <= 1'b0;
        wr(10'h034, 8'h08, 1'b0);
        repeat (2 * TO) @(posedge clk);
        #1 cmp_sig("prog", {7'h00, nvm.progEnable}, 8'h01);
        wr(10'h034, 8'h00, 1'b0);
        #1 cmp_sig("prog", {7'h00, nvm.progEnable}, 8'h00);
        for (int v = 0; v < 4; v++) begin
            wr(10'h038, 8'(v), 1'b0);
            #1 cmp_sig("owner", {6'h00, nvm.coreHold, nvm.memOwnerExt}, 8'(v));
            rd(10'h038, 8'(v), 1'b0);
        end
        host.pulse(1'b1, 20'd200, 6'h00);
        host.pulse(1'b1, 20'd40, 6'h00);
        rd(10'h050, 8'h00, 1'b0);
        for (int k = 0; k < 8; k++) begin
            host.pulse(k < 2, (k == 0) ? 20'd201 : 20'd39, (k < 2) ? 6'h00 : 6'(1 << (7 - k)));
            expErr = expErr | 8'(1 << k);
            rd(10'h050, expErr, 1'b0);
            #1 cmp_sig("irq", 8'h00, {7'h00, irq});
        end
        // interrupt mask and clear
        rd(10'h058, 8'hFF, 1'b0);
        wr(10'h05C, 8'h10, 1'b0);
        #1 cmp_sig("irq", {7'h00, irq}, 8'h01);
        wr(10'h058, 8'h10, 1'b0);
        #1 cmp_sig("irq", {7'h00, irq}, 8'h00);
        rd(10'h058, 8'hEF, 1'b0);
        wr(10'h050, 8'hF0, 1'b0);
        rd(10'h050, 8'hF0, 1'b0);
        wr(10'h050, 8'h00, 1'b0);
        rd(10'h050, 8'h00, 1'b0);
        wr(10'h038, 8'h03, 1'b0);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 cmp_sig("nvm", 8'h00, {1'b0, nvm});
        all_zero();
        report_and_stop;
    end
endmodule // test_space_control_registers_tb
